// ---- design/crj_pkg.sv ----
// Package of register map, field positions and line coding constants
package crj_pkg;
    localparam int          ADDR_W        = 2;
    localparam int          DATA_W        = 32;
    localparam logic [1:0]  CFG_IDX       = 2'h0;
    localparam logic [1:0]  ATTN_IDX      = 2'h1;
    localparam logic [1:0]  STAT_IDX      = 2'h2;
    localparam int          RAIL_BIT      = 0;
    localparam int          STS_BIT       = 1;
    localparam int          EURO_BIT      = 2;
    localparam int          ATTN_LO_BIT   = 0;
    localparam int          ATTN_PATH_BIT = 1;
    localparam int          ATTN_HI_BIT   = 2;
    localparam int          ATTN_RST_BIT  = 3;
    localparam logic [7:0]  CFG_RESET     = 8'h00;
    localparam logic [7:0]  ATTN_RESET    = 8'h00;
    localparam logic [7:0]  CFG_WMASK     = 8'h07;
    localparam logic [7:0]  ATTN_WMASK    = 8'h0f;
    localparam int          STAT_ON_BIT   = 6;
    localparam int          STAT_RST_BIT  = 7;
    localparam int          FIFO_MAX      = 32;
    localparam int          PTR_W         = 5;
    localparam logic [5:0]  DEPTH_SHORT   = 6'h10;
    localparam logic [5:0]  DEPTH_LONG    = 6'h20;
    localparam int          PIPE_LEN      = 4;
    localparam logic [2:0]  RUN_EURO      = 3'h4;
    localparam logic [2:0]  RUN_T3        = 3'h3;
    localparam logic [1:0]  SYM_ZERO      = 2'h0;
    localparam logic [1:0]  SYM_MARK      = 2'h1;
    localparam logic [1:0]  SYM_VIOL      = 2'h2;
    localparam int          PIN_N         = 5;
    localparam logic [4:0]  PIN_RESET     = 5'h00;
    typedef enum logic [1:0] {CRJ_RATE_T3, CRJ_RATE_EURO, CRJ_RATE_SONET}
        crj_rate_e;
endpackage

// ---- design/crj_coder_if.sv ----
// Interface between the channel logic and its line coder
`timescale 1ns/10ps
interface crj_coder_if;
    logic tick;
    logic euroMode;
    logic encIn;
    logic encPos;
    logic encNeg;
    logic decPos;
    logic decNeg;
    logic decData;
    logic decViol;
    modport coder (input tick, euroMode, encIn, decPos, decNeg,
                   output encPos, encNeg, decData, decViol);
    modport user  (output tick, euroMode, encIn, decPos, decNeg,
                   input encPos, encNeg, decData, decViol);
endinterface

// ---- design/crj_line_coder.sv ----
// Zero-substitution line encoder and decoder for one channel
`timescale 1ns/10ps
module crj_line_coder
    import crj_pkg::*;
(
    input  wire logic   mclk,
    input  wire logic   arst_n,
    crj_coder_if.coder  cif
);
    logic [1:0]          encPipe_reg [PIPE_LEN];
    logic [2:0]          encRun_reg;
    logic                encOdd_reg;
    logic                encPol_reg;
    logic [PIPE_LEN-1:0] decPipe_reg;
    logic [2:0]          decRun_reg;
    logic                decPol_reg;
    logic                decSeen_reg;
    logic [1:0]          rawHist_reg;
    logic [2:0]          runLen;
    logic                decPulse;
    logic                decIsV;
    logic                decBadV;
    logic                decExcess;

    assign runLen    = cif.euroMode ? RUN_EURO : RUN_T3;
    assign decPulse  = cif.decPos | cif.decNeg;
    assign decIsV    = decPulse && decSeen_reg && (cif.decPos == decPol_reg);
    // Zeros ahead of a violation are judged on raw line pulses, so a
    // violation straight after another violation is still flagged
    assign decBadV   = decIsV &&
                       (cif.euroMode ? |rawHist_reg : rawHist_reg[0]);
    assign decExcess = !decPulse && (decRun_reg == runLen - 3'h1);

    ////////////////////////////////////////////////////////////////////////
    // Encoder: marks enter, zero runs are replaced by B/V patterns
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < PIPE_LEN; i++)
                encPipe_reg[i] <= SYM_ZERO;
            encRun_reg <= 3'h0;
            encOdd_reg <= 1'b0;
        end
        else if (cif.tick)
        begin
            for (int i = 1; i < PIPE_LEN; i++)
                encPipe_reg[i] <= encPipe_reg[i-1];
            if (cif.encIn)
            begin
                encPipe_reg[0] <= SYM_MARK;
                encOdd_reg     <= ~encOdd_reg;
                encRun_reg     <= 3'h0;
            end
            else if (encRun_reg == runLen - 3'h1)
            begin
                encPipe_reg[0] <= SYM_VIOL;
                // Even mark count: insert a balancing pulse ahead
                if (!encOdd_reg && cif.euroMode)
                    encPipe_reg[3] <= SYM_MARK;
                else if (!encOdd_reg)
                    encPipe_reg[2] <= SYM_MARK;
                encOdd_reg <= 1'b0;
                encRun_reg <= 3'h0;
            end
            else
            begin
                encPipe_reg[0] <= SYM_ZERO;
                encRun_reg     <= encRun_reg + 3'h1;
            end
        end
    end

    // Polarity: marks alternate, violations repeat the last polarity
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cif.encPos <= 1'b0;
            cif.encNeg <= 1'b0;
            encPol_reg <= 1'b0;
        end
        else if (cif.tick)
        begin
            unique case (encPipe_reg[PIPE_LEN-1])
                SYM_MARK:
                begin
                    cif.encPos <= ~encPol_reg;
                    cif.encNeg <= encPol_reg;
                    encPol_reg <= ~encPol_reg;
                end
                SYM_VIOL:
                begin
                    cif.encPos <= encPol_reg;
                    cif.encNeg <= ~encPol_reg;
                end
                default:
                begin
                    cif.encPos <= 1'b0;
                    cif.encNeg <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoder: strips B/V patterns, flags bad violations and zero runs
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            decPipe_reg  <= '0;
            decRun_reg   <= 3'h0;
            decPol_reg   <= 1'b0;
            decSeen_reg  <= 1'b0;
            rawHist_reg  <= 2'h0;
            cif.decData  <= 1'b0;
            cif.decViol  <= 1'b0;
        end
        else if (cif.tick)
        begin
            decPipe_reg <= {decPipe_reg[PIPE_LEN-2:0], decPulse && !decIsV};
            rawHist_reg <= {rawHist_reg[0], decPulse};
            if (decIsV && cif.euroMode)
                decPipe_reg[3] <= 1'b0;
            else if (decIsV)
                decPipe_reg[2] <= 1'b0;
            if (decPulse && !decIsV)
            begin
                decPol_reg  <= cif.decPos;
                decSeen_reg <= 1'b1;
            end
            decRun_reg  <= (decPulse || decExcess) ? 3'h0 : decRun_reg + 3'h1;
            cif.decData <= decPipe_reg[PIPE_LEN-1];
            cif.decViol <= decBadV | decExcess;
        end
    end
endmodule

// ---- design/crj_channel_cfg.sv ----
// Channel rate, rail mode and jitter attenuator control with datapath
`timescale 1ns/10ps
module crj_channel_cfg
    import crj_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              recoveredClockAlias,
    input  wire logic              txPositiveRailIn,
    input  wire logic              txNegativeRailIn,
    input  wire logic              lineRxTip,
    input  wire logic              lineRxRing,
    output logic                   rxPositiveRailOut,
    output logic                   rxNegativeOrViolationOut,
    output logic                   lineTxPos,
    output logic                   lineTxNeg,
    output logic                   rateEuro,
    output logic                   rateSonet,
    output logic                   rateT3
);
    logic [7:0]        cfg_reg;
    logic [7:0]        attn_reg;
    logic              wait_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [PIN_N-1:0]  pinS1_reg;
    logic [PIN_N-1:0]  pinS2_reg;
    logic [PIN_N-1:0]  pinS3_reg;
    logic [PIN_N-1:0]  pinF_reg;
    logic              clkPrev_reg;
    logic [1:0]        fifoMem_reg [FIFO_MAX];
    logic [PTR_W-1:0]  wrPtr_reg;
    logic [PTR_W-1:0]  rdPtr_reg;
    logic [5:0]        fifoCount_reg;
    logic              rxPos_reg;
    logic              rxNeg_reg;
    logic              txPos_reg;
    logic              txNeg_reg;
    logic              rEuro_reg;
    logic              rSonet_reg;
    logic              rT3_reg;
    logic              tick;
    logic              access;
    logic              cfgWrite;
    logic              attnWrite;
    logic              flushStart;
    logic              flushing;
    logic              singleRail;
    logic              euroSel;
    logic              stsSel;
    logic              attnOn;
    logic              attnTx;
    logic [5:0]        fifoDepth;
    logic [1:0]        txPair;
    logic [1:0]        rxPair;
    logic [1:0]        fifoIn;
    logic [1:0]        fifoOut;
    logic [1:0]        lineOut;
    logic [1:0]        rxLine;
    logic              tipF;
    logic              ringF;
    logic              txPosF;
    logic              txNegF;
    crj_rate_e         rateMode;

    crj_coder_if coderIf ();

    crj_line_coder u_coder (
        .mclk   (mclk),
        .arst_n (arst_n),
        .cif    (coderIf.coder)
    );

    ////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle, then the access completes
    assign access    = (avs_read | avs_write) && !wait_reg;
    assign cfgWrite  = access && avs_write && avs_byteenable[0] &&
                       avs_address == CFG_IDX;
    assign attnWrite = access && avs_write && avs_byteenable[0] &&
                       avs_address == ATTN_IDX;
    assign flushStart = attnWrite && avs_writedata[ATTN_RST_BIT] &&
                        !attn_reg[ATTN_RST_BIT];

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            wait_reg <= 1'b1;
        else
            wait_reg <= !((avs_read | avs_write) && wait_reg);
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_reg <= '0;
        else if ((avs_read | avs_write) && wait_reg)
        begin
            unique case (avs_address)
                CFG_IDX:  rdata_reg <= {24'h0, cfg_reg};
                ATTN_IDX: rdata_reg <= {24'h0, attn_reg};
                STAT_IDX: rdata_reg <= {24'h0, flushing, attnOn, fifoCount_reg};
                default:  rdata_reg <= '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            cfg_reg <= CFG_RESET;
        else if (cfgWrite)
            cfg_reg <= avs_writedata[7:0] & CFG_WMASK;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            attn_reg <= ATTN_RESET;
        else if (attnWrite)
            attn_reg <= avs_writedata[7:0] & ATTN_WMASK;
    end

    ////////////////////////////////////////////////////////////////////////
    // Rate and rail decode
    assign euroSel    = cfg_reg[EURO_BIT];
    assign stsSel     = cfg_reg[STS_BIT];
    assign singleRail = cfg_reg[RAIL_BIT];

    always_comb
    begin
        if (euroSel)
            rateMode = CRJ_RATE_EURO;
        else if (stsSel)
            rateMode = CRJ_RATE_SONET;
        else
            rateMode = CRJ_RATE_T3;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rEuro_reg  <= 1'b0;
            rSonet_reg <= 1'b0;
            rT3_reg    <= 1'b0;
        end
        else
        begin
            unique case (rateMode)
                CRJ_RATE_EURO:  {rEuro_reg, rSonet_reg, rT3_reg} <= 3'h4;
                CRJ_RATE_SONET: {rEuro_reg, rSonet_reg, rT3_reg} <= 3'h2;
                CRJ_RATE_T3:    {rEuro_reg, rSonet_reg, rT3_reg} <= 3'h1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; a filtered bit moves when stages 2 and 3 agree
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinS1_reg   <= PIN_RESET;
            pinS2_reg   <= PIN_RESET;
            pinS3_reg   <= PIN_RESET;
            pinF_reg    <= PIN_RESET;
            clkPrev_reg <= 1'b0;
        end
        else
        begin
            pinS1_reg   <= {recoveredClockAlias, txPositiveRailIn,
                            txNegativeRailIn, lineRxTip, lineRxRing};
            pinS2_reg   <= pinS1_reg;
            pinS3_reg   <= pinS2_reg;
            pinF_reg    <= (pinS2_reg & pinS3_reg) |
                           (pinF_reg & (pinS2_reg ^ pinS3_reg));
            clkPrev_reg <= pinF_reg[4];
        end
    end

    assign tick   = pinF_reg[4] && !clkPrev_reg;
    assign txPosF = pinF_reg[3];
    assign txNegF = pinF_reg[2];
    assign tipF   = pinF_reg[1];
    assign ringF  = pinF_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // Jitter attenuator FIFO: fills to half depth, then one in, one out
    assign attnOn    = !attn_reg[ATTN_HI_BIT];
    assign fifoDepth = attn_reg[ATTN_LO_BIT] ? DEPTH_LONG : DEPTH_SHORT;
    assign attnTx    = attn_reg[ATTN_PATH_BIT];
    assign flushing  = attn_reg[ATTN_RST_BIT];
    assign fifoIn    = attnTx ? txPair : rxPair;
    assign fifoOut   = (fifoCount_reg >= (fifoDepth >> 1)) ?
                       fifoMem_reg[rdPtr_reg] : 2'h0;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < FIFO_MAX; i++)
                fifoMem_reg[i] <= 2'h0;
            wrPtr_reg     <= '0;
            rdPtr_reg     <= '0;
            fifoCount_reg <= 6'h0;
        end
        else if (flushStart || flushing || attnWrite || !attnOn)
        begin
            for (int i = 0; i < FIFO_MAX; i++)
                fifoMem_reg[i] <= 2'h0;
            wrPtr_reg     <= '0;
            rdPtr_reg     <= '0;
            fifoCount_reg <= 6'h0;
        end
        else if (tick)
        begin
            fifoMem_reg[wrPtr_reg] <= fifoIn;
            wrPtr_reg <= (6'(wrPtr_reg) == fifoDepth - 6'h1) ?
                         '0 : wrPtr_reg + 1'b1;
            if (fifoCount_reg >= (fifoDepth >> 1))
                rdPtr_reg <= (6'(rdPtr_reg) == fifoDepth - 6'h1) ?
                             '0 : rdPtr_reg + 1'b1;
            else
                fifoCount_reg <= fifoCount_reg + 6'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit and receive data paths
    assign coderIf.tick     = tick;
    assign coderIf.euroMode = euroSel;
    assign coderIf.encIn    = txPosF;
    assign txPair  = singleRail ? {coderIf.encPos, coderIf.encNeg}
                                : {txNegF, txPosF};
    assign rxPair  = {tipF, ringF};
    assign lineOut = (attnOn && attnTx) ? fifoOut : txPair;
    assign rxLine  = (attnOn && !attnTx) ? fifoOut : rxPair;
    assign coderIf.decPos = rxLine[1];
    assign coderIf.decNeg = rxLine[0];

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rxPos_reg <= 1'b0;
            rxNeg_reg <= 1'b0;
            txPos_reg <= 1'b0;
            txNeg_reg <= 1'b0;
        end
        else if (tick)
        begin
            txPos_reg <= lineOut[1];
            txNeg_reg <= lineOut[0];
            if (singleRail)
            begin
                rxPos_reg <= coderIf.decData;
                rxNeg_reg <= coderIf.decViol;
            end
            else
            begin
                rxPos_reg <= rxLine[1];
                rxNeg_reg <= rxLine[0];
            end
        end
    end

    assign avs_readdata             = rdata_reg;
    assign avs_waitrequest          = wait_reg;
    assign rxPositiveRailOut        = rxPos_reg;
    assign rxNegativeOrViolationOut = rxNeg_reg;
    assign lineTxPos                = txPos_reg;
    assign lineTxNeg                = txNeg_reg;
    assign rateEuro                 = rEuro_reg;
    assign rateSonet                = rSonet_reg;
    assign rateT3                   = rT3_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    euro_override_a: assert property (@(posedge mclk) disable iff (!arst_n)
        euroSel |=> rEuro_reg && !rSonet_reg && !rT3_reg)
        else $error("E3 select did not override rate");

    rate_pick_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !euroSel |=> rSonet_reg == $past(stsSel) && rT3_reg != $past(stsSel))
        else $error("DS3 or STS-1 rate wrong");

    single_rx_a: assert property (@(posedge mclk) disable iff (!arst_n)
        tick && singleRail |=> rxPos_reg == $past(coderIf.decData) &&
                               rxNeg_reg == $past(coderIf.decViol))
        else $error("Single rail receive outputs wrong");

    dual_tx_a: assert property (@(posedge mclk) disable iff (!arst_n)
        tick && !singleRail && !(attnOn && attnTx)
        |=> txPos_reg == $past(txNegF) && txNeg_reg == $past(txPosF))
        else $error("Dual rail transmit source wrong");

    dual_rx_a: assert property (@(posedge mclk) disable iff (!arst_n)
        tick && !singleRail && !(attnOn && !attnTx)
        |=> rxPos_reg == $past(tipF) && rxNeg_reg == $past(ringF))
        else $error("Dual rail receive pulse wrong");

    rx_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !tick ##1 !tick |-> $stable(rxNeg_reg) && $stable(rxPos_reg))
        else $error("Receive output changed mid period");

    flush_start_a: assert property (@(posedge mclk) disable iff (!arst_n)
        flushStart |=> fifoCount_reg == 6'h0 && wrPtr_reg == '0 &&
                       rdPtr_reg == '0)
        else $error("Attenuator reset left pointers");

    flush_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
        flushing ##1 flushing |-> fifoCount_reg == 6'h0 && fifoOut == 2'h0)
        else $error("FIFO ran while reset bit held");

    depth_sel_a: assert property (@(posedge mclk) disable iff (!arst_n)
        attnOn && attn_reg[ATTN_LO_BIT] |-> fifoDepth == DEPTH_LONG)
        else $error("FIFO depth select wrong");

    reserved_zero_a: assert property (@(posedge mclk) disable iff (!arst_n)
        attn_reg[7:4] == 4'h0)
        else $error("Reserved attenuator bits set");

    tx_path_a: assert property (@(posedge mclk) disable iff (!arst_n)
        tick && attnOn && attnTx |=> txPos_reg == $past(fifoOut[1]))
        else $error("Attenuator not in transmit path");
endmodule

// ---- sim/crj_frame_partner.sv ----
// Model of the system-side framing equipment and a line loop
`timescale 1ns/10ps
module crj_frame_partner
(
    input  wire logic [1:0] mode,
    input  wire logic       txOnes,
    input  wire logic       lineTxPos,
    input  wire logic       lineTxNeg,
    output logic            linkClk,
    output logic            txPos,
    output logic            txNeg,
    output logic            tip,
    output logic            ring
);
    logic [1:0] slot;
    logic       loopPos;
    logic       loopNeg;
    initial
    begin
        {linkClk, txPos, txNeg, tip, ring, loopPos, loopNeg} = 7'h00;
        slot = 2'h0;
        #3;
        forever #40 linkClk = ~linkClk;
    end
    always @(posedge linkClk)
    begin
        loopPos <= lineTxPos;
        loopNeg <= lineTxNeg;
    end
    // Data changes mid-period so it is steady around each rising edge
    always @(negedge linkClk)
    begin
        slot  <= slot + 2'h1;
        txNeg <= (slot == 2'h1);
        txPos <= txOnes | (slot == 2'h3);
        tip   <= (mode == 2'h1) ? loopPos : (mode == 2'h2) | (slot == 2'h0);
        ring  <= (mode == 2'h1) ? loopNeg : (mode == 2'h0) & (slot == 2'h2);
    end
endmodule

// ---- sim/crj_channel_cfg_tb.sv ----
// Self-checking bench for the channel configuration block
`timescale 1ns/10ps
module crj_channel_cfg_tb import crj_pkg::*;;
    logic        mclk, arst_n, rd, wr, txOnes, chkRun, cnting;
    logic [1:0]  addr, mode;
    logic [31:0] wdata, rdata, q;
    logic [3:0]  ben, prev, outs;
    logic        waitreq, rxP, rxN, ltP, ltN, rE, rS, rT;
    logic        lclk, tP, tN, tip, ring;
    int          nFail, checkCount, cyc, runP, runN, cnt[5];
    assign outs = {ltN, ltP, rxN, rxP};
    crj_channel_cfg dut (.mclk(mclk), .arst_n(arst_n), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
        .avs_byteenable(ben), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .recoveredClockAlias(lclk),
        .txPositiveRailIn(tP), .txNegativeRailIn(tN), .lineRxTip(tip),
        .lineRxRing(ring), .rxPositiveRailOut(rxP),
        .rxNegativeOrViolationOut(rxN), .lineTxPos(ltP), .lineTxNeg(ltN),
        .rateEuro(rE), .rateSonet(rS), .rateT3(rT));
    crj_frame_partner model (.mode(mode), .txOnes(txOnes), .lineTxPos(ltP),
        .lineTxNeg(ltN), .linkClk(lclk), .txPos(tP), .txNeg(tN), .tip(tip),
        .ring(ring));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            nFail++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [1:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= d;
        ben <= be;
        do @(posedge mclk); while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rchk(input logic [1:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        check(q, {24'h0, e});
    endtask
    // Settle the link, then count output rises over 64 link periods
    task automatic window(input logic [1:0] m, input logic ones);
        mode <= m;
        txOnes <= ones;
        repeat (300) @(posedge mclk);
        cnt = '{default: 0};
        cnting <= 1'b1;
        repeat (512) @(posedge mclk);
        cnting <= 1'b0;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            nFail++;
            completeRun();
        end
        prev <= outs;
        runP <= rxP ? runP + 1 : 0;
        runN <= rxN ? runN + 1 : 0;
        if (chkRun && prev[0] && !rxP)
            check(runP, 8);
        if (chkRun && prev[1] && !rxN)
            check(runN, 8);
        for (int i = 0; i < 4; i++)
            cnt[i] += int'(cnting && outs[i] && !prev[i]);
        cnt[4] += int'(cnting && rxN);
    end
    initial
    begin
        {arst_n, rd, wr, txOnes, chkRun, cnting} = 6'h00;
        addr = 2'h0;
        mode = 2'h0;
        wdata = 32'h0;
        ben = 4'hf;
        prev = 4'h0;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rchk(CFG_IDX, CFG_RESET);
        rchk(ATTN_IDX, ATTN_RESET);
        check({rT, rS, rE}, 3'h4);
        for (int v = 0; v < 4; v++)
        begin
            bus(1'b1, CFG_IDX, 32'(v << 1), 4'hf);
            rchk(CFG_IDX, 8'(v << 1));
            check({rT, rS, rE}, v[1] ? 3'h1 : v[0] ? 3'h2 : 3'h4);
        end
        bus(1'b1, CFG_IDX, 32'hffff_ffff, 4'hf);
        rchk(CFG_IDX, CFG_WMASK);
        bus(1'b1, CFG_IDX, 32'h0, 4'he);
        rchk(CFG_IDX, CFG_WMASK);
        bus(1'b1, 2'h3, 32'hff, 4'hf);
        rchk(2'h3, 8'h00);
        bus(1'b1, ATTN_IDX, 32'hf4, 4'hf);
        rchk(ATTN_IDX, 8'h04);
        $display("test registers done");
        for (int v = 0; v < 4; v++)
        begin
            bus(1'b1, ATTN_IDX, 32'({v[1], 1'b0, v[0]}), 4'hf);
            repeat (300) @(posedge mclk);
            bus(1'b0, STAT_IDX, 32'h0, 4'hf);
            check(q[6:0], v[1] ? 7'h0 : {1'b1, (v[0] ? DEPTH_LONG :
                DEPTH_SHORT) >> 1});
        end
        $display("test attenuator modes done");
        bus(1'b1, CFG_IDX, 32'h0, 4'hf);
        repeat (40) @(posedge mclk);
        chkRun <= 1'b1;
        for (int p = 0; p < 3; p++)
        begin
            bus(1'b1, ATTN_IDX, p == 0 ? 32'h4 : 32'((p - 1) << 1), 4'hf);
            window(2'h0, 1'b1);
            for (int i = 0; i < 4; i++)
                check(cnt[i], i == 3 ? 0 : 16);
        end
        chkRun <= 1'b0;
        $display("test dual rail done");
        bus(1'b1, CFG_IDX, 32'h1, 4'hf);
        for (int o = 0; o < 3; o++)
        begin
            if (o == 2)
                bus(1'b1, CFG_IDX, 32'h5, 4'hf);
            window(2'h1, o == 1);
            check(cnt[0], o == 1 ? 0 : 16);
            check(cnt[1], 0);
            if (o == 1)
                check({rxP, rxN}, 2'h2);
        end
        window(2'h2, 1'b0);
        check(cnt[4] > 0, 1);
        $display("test single rail done");
        bus(1'b1, ATTN_IDX, 32'h8, 4'hf);
        repeat (200) @(posedge mclk);
        bus(1'b1, ATTN_IDX, 32'h8, 4'hf);
        bus(1'b0, STAT_IDX, 32'h0, 4'hf);
        check({q[7], q[5:0]}, 7'h40);
        bus(1'b1, ATTN_IDX, 32'h0, 4'hf);
        repeat (300) @(posedge mclk);
        rchk(STAT_IDX, {2'h1, DEPTH_SHORT >> 1});
        $display("test fifo reset done");
        completeRun();
    end
endmodule
